// ==== core/zrj_judge.sv ====
// Purpose: Three-way judgment against upper and lower thresholds with hysteresis
// Assumes: Thresholds and value share one scale; hysteresis is not negative
// Notes:   Output is the one-hot state, so exactly one judgment is active
module zrj_judge
    import zrj_pkg::*;
(
    input  wire logic               i_ref_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_valid,
    input  wire logic signed [31:0] i_value,
    input  wire logic signed [31:0] i_thr_high,
    input  wire logic signed [31:0] i_thr_low,
    input  wire logic signed [31:0] i_hyst,
    output zrj_pkg::zrj_judge_t     o_judge
);
    typedef struct packed {
        zrj_judge_t j;
    } zrj_jst_t;

    zrj_jst_t st;
    zrj_jst_t next_st;

    // Enter on crossing, leave only after backing off by the hysteresis width
    always_comb
    begin
        next_st = st;
        if (i_valid)
        begin
            case (st.j)
                ZRJ_J_PASS:
                begin
                    if (i_value > i_thr_high)
                        next_st.j = ZRJ_J_HIGH;
                    else if (i_value < i_thr_low)
                        next_st.j = ZRJ_J_LOW;
                end
                ZRJ_J_HIGH:
                begin
                    if (i_value < i_thr_low)
                        next_st.j = ZRJ_J_LOW;
                    else if (i_value <= 32'(i_thr_high - i_hyst))
                        next_st.j = ZRJ_J_PASS;
                end
                ZRJ_J_LOW:
                begin
                    if (i_value > i_thr_high)
                        next_st.j = ZRJ_J_HIGH;
                    else if (i_value >= 32'(i_thr_low + i_hyst))
                        next_st.j = ZRJ_J_PASS;
                end
                default:
                    next_st.j = ZRJ_J_PASS;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            st <= '{j: ZRJ_J_PASS};
        else
            st <= next_st;
    end

    assign o_judge = st.j;

endmodule : zrj_judge

// ==== core/zrj_top.sv ====
// Purpose: Zero reset, reference offset, zero retention and threshold judgment
// Assumes: Measured and held values arrive already processed by hold, trigger and scaling
// Notes:   Keys, switch and freeze are pins and are synchronised here
//
// The implementer's own choices: the address map and register access over APB.
module zrj_top
    import zrj_pkg::*;
#(
    parameter int unsigned P_ESC_HOLD_CYC = ZRJ_ESC_HOLD_CYC
)
(
    input  wire logic               i_ref_clk,
    input  wire logic               i_rstn,
    input  zrj_pkg::zrj_apb_req_t   i_apb,
    output logic                    o_pready,
    output logic [31:0]             o_prdata,
    output logic                    o_pslverr,
    input  wire logic               i_key_set,
    input  wire logic               i_key_esc,
    input  wire logic               i_thr_sel_high,
    input  wire logic               i_output_freeze_input,
    input  wire logic               i_meas_valid,
    input  wire logic signed [31:0] i_meas_value,
    input  wire logic               i_hold_active,
    input  wire logic signed [31:0] i_hold_value,
    input  zrj_pkg::zrj_nvm_rec_t   i_nvm_rec,
    output logic                    o_nvm_wr,
    output zrj_pkg::zrj_nvm_rec_t   o_nvm_rec,
    output logic signed [31:0]      o_dev_value,
    output logic [15:0]             o_lin_code,
    output logic                    o_high,
    output logic                    o_pass,
    output logic                    o_low
);
    // Pin bit positions in the synchroniser vectors
    localparam int unsigned PIN_SET    = 0;
    localparam int unsigned PIN_ESC    = 1;
    localparam int unsigned PIN_SEL    = 2;
    localparam int unsigned PIN_FREEZE = 3;

    typedef struct packed {
        logic [3:0]         sync1;
        logic [3:0]         sync2;
        logic [3:0]         sync3;
        logic [3:0]         pin;
        logic               set_prev;
        logic [31:0]        esc_cnt;
        logic               esc_done;
        logic               teach_mode;
        logic               hold_type;
        logic               retain_en;
        logic signed [31:0] offset;
        logic signed [31:0] thr_high;
        logic signed [31:0] thr_low;
        logic signed [31:0] hyst;
        logic [15:0]        lin_p1;
        logic [15:0]        lin_p2;
        zrj_nvm_rec_t       zero;
        logic               restored;
        logic               teach_pend;
        logic               nvm_wr;
        zrj_nvm_rec_t       nvm_rec;
        logic signed [31:0] dev_out;
        logic [15:0]        lin_out;
        zrj_judge_t         judge;
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
    } zrj_state_t;

    localparam zrj_state_t ST_RST = '{
        offset:   ZRJ_OFFSET_RST,
        thr_high: ZRJ_THR_HI_RST,
        thr_low:  ZRJ_THR_LO_RST,
        hyst:     ZRJ_HYST_RST,
        lin_p1:   ZRJ_LIN_P1_RST,
        lin_p2:   ZRJ_LIN_P2_RST,
        judge:    ZRJ_J_PASS,
        default:  '0
    };

    zrj_state_t         st;
    zrj_state_t         next_st;
    zrj_judge_t         judge_now;
    logic signed [31:0] dev_now;

    // True for every mapped register offset
    function automatic logic addr_ok(input logic [11:0] a);
        case (a)
            ZRJ_OFS_CTRL, ZRJ_OFS_OFFSET, ZRJ_OFS_THR_HIGH, ZRJ_OFS_THR_LOW, ZRJ_OFS_HYST,
            ZRJ_OFS_LIN_PTS, ZRJ_OFS_STATUS, ZRJ_OFS_ZERO_LVL, ZRJ_OFS_DEV:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // Saturating clamp of a signed value into a window
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        if (v < lo)
            clamp = lo;
        else if (v > hi)
            clamp = hi;
        else
            clamp = v;
    endfunction : clamp

    // Linear code: midpoint of the two scaling points plus the offset-free deviation
    function automatic logic [15:0] lin_code(input logic [15:0] p1,
                                             input logic [15:0] p2,
                                             input logic signed [31:0] d);
        logic signed [33:0] mid;
        logic signed [33:0] sum;
        mid = (34'(p1) + 34'(p2)) >>> 1;
        sum = mid + 34'(d);
        if (sum < 34'sd0)
            lin_code = 16'h0000;
        else if (sum > 34'sh0ffff)
            lin_code = 16'hffff;
        else
            lin_code = sum[15:0];
    endfunction : lin_code

    // Deviation from the zero point plus reference, or the raw value when not zeroed
    always_comb
    begin
        if (st.zero.zeroed)
            dev_now = 32'(i_meas_value - st.zero.level + st.offset);
        else
            dev_now = i_meas_value;
    end

    zrj_judge zrj_judge_inst (
        .i_ref_clk  (i_ref_clk),
        .i_rstn     (i_rstn),
        .i_valid    (i_meas_valid),
        .i_value    (dev_now),
        .i_thr_high (st.thr_high),
        .i_thr_low  (st.thr_low),
        .i_hyst     (st.hyst),
        .o_judge    (judge_now)
    );

    // Next-state logic for keys, zero reset, teaching, outputs and the bus slave
    always_comb
    begin
        logic               set_edge;
        logic               esc_lvl;
        logic               do_zero;
        logic               do_cancel;
        logic               frozen;
        logic               wr_acc;
        logic signed [31:0] teach_val;
        set_edge  = 1'b0;
        esc_lvl   = 1'b0;
        do_zero   = 1'b0;
        do_cancel = 1'b0;
        frozen    = 1'b0;
        wr_acc    = 1'b0;
        teach_val = '0;
        next_st   = st;

        // Three-stage pin synchroniser; level changes once stages two and three agree
        next_st.sync1 = {i_output_freeze_input, i_thr_sel_high, i_key_esc, i_key_set};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.pin   = (st.sync3 & ~(st.sync2 ^ st.sync3)) | (st.pin & (st.sync2 ^ st.sync3));

        set_edge = st.pin[PIN_SET] & ~st.set_prev;
        esc_lvl  = st.pin[PIN_ESC];
        frozen   = st.pin[PIN_FREEZE];
        next_st.set_prev = st.pin[PIN_SET];

        // Zero reset on the set key, run mode only
        if (set_edge && !st.teach_mode)
        begin
            if (!st.hold_type)
                do_zero = 1'b1;
            else if (i_hold_active)
                do_zero = 1'b1;
        end

        // Escape must stay down without a break; a short press only resets the count
        if (esc_lvl && !st.teach_mode)
        begin
            if (st.esc_cnt < (P_ESC_HOLD_CYC - 1))
                next_st.esc_cnt = st.esc_cnt + 32'h0000_0001;
            else if (!st.esc_done)
            begin
                do_cancel        = 1'b1;
                next_st.esc_done = 1'b1;
            end
        end
        else
        begin
            next_st.esc_cnt  = '0;
            next_st.esc_done = 1'b0;
        end

        next_st.nvm_wr = 1'b0;
        if (do_zero)
        begin
            next_st.zero.zeroed = 1'b1;
            next_st.zero.level  = st.hold_type ? i_hold_value : i_meas_value;
            if (st.retain_en)
            begin
                next_st.nvm_wr  = 1'b1;
                next_st.nvm_rec = next_st.zero;
            end
        end
        else if (do_cancel)
        begin
            next_st.zero.zeroed = 1'b0;
            if (st.retain_en)
            begin
                next_st.nvm_wr  = 1'b1;
                next_st.nvm_rec = next_st.zero;
            end
        end

        // Power-up restore of whatever the store last held; without retention only a save wrote it
        if (!st.restored)
        begin
            next_st.restored = 1'b1;
            next_st.zero     = i_nvm_rec;
        end

        // Teaching captures the processed value into the selected threshold
        if (st.teach_pend && i_meas_valid)
        begin
            teach_val = i_hold_active ? i_hold_value : dev_now;
            if (st.pin[PIN_SEL])
                next_st.thr_high = teach_val;
            else
                next_st.thr_low = teach_val;
            next_st.teach_pend = 1'b0;
        end
        if (!st.teach_mode)
            next_st.teach_pend = 1'b0;

        // External outputs follow the measurement unless frozen; judging runs in both modes
        if (!frozen)
        begin
            next_st.judge = judge_now;
            if (i_meas_valid)
            begin
                next_st.dev_out = dev_now;
                next_st.lin_out = lin_code(st.lin_p1, st.lin_p2,
                                           32'(dev_now - (st.zero.zeroed ? st.offset : 32'sh0)));
            end
        end

        // APB: data captured in setup, pready one cycle later; writes land on the completing edge
        next_st.pready  = i_apb.psel && !i_apb.penable && !st.pready;
        next_st.pslverr = i_apb.psel && !i_apb.penable && !addr_ok(i_apb.paddr);
        wr_acc = i_apb.psel && i_apb.penable && st.pready && i_apb.pwrite && !st.pslverr;
        if (i_apb.psel && !i_apb.penable)
        begin
            case (i_apb.paddr)
                ZRJ_OFS_CTRL:
                    next_st.prdata = {27'h0, st.teach_pend, 1'b0, st.retain_en, st.hold_type, st.teach_mode};
                ZRJ_OFS_OFFSET:
                    next_st.prdata = st.offset;
                ZRJ_OFS_THR_HIGH:
                    next_st.prdata = st.thr_high;
                ZRJ_OFS_THR_LOW:
                    next_st.prdata = st.thr_low;
                ZRJ_OFS_HYST:
                    next_st.prdata = st.hyst;
                ZRJ_OFS_LIN_PTS:
                    next_st.prdata = {st.lin_p2, st.lin_p1};
                ZRJ_OFS_STATUS:
                    next_st.prdata = {26'h0, st.teach_pend, frozen, st.judge == ZRJ_J_LOW,
                                      st.judge == ZRJ_J_PASS, st.judge == ZRJ_J_HIGH, st.zero.zeroed};
                ZRJ_OFS_ZERO_LVL:
                    next_st.prdata = st.zero.level;
                ZRJ_OFS_DEV:
                    next_st.prdata = st.dev_out;
                default:
                    next_st.prdata = 32'h0000_0000;
            endcase
        end

        if (wr_acc)
        begin
            case (i_apb.paddr)
                ZRJ_OFS_CTRL:
                begin
                    next_st.teach_mode = i_apb.pwdata[ZRJ_CTRL_TEACH];
                    next_st.hold_type  = i_apb.pwdata[ZRJ_CTRL_HOLDTYP];
                    next_st.retain_en  = i_apb.pwdata[ZRJ_CTRL_RETAIN];
                    if (i_apb.pwdata[ZRJ_CTRL_SAVE])
                    begin
                        next_st.nvm_wr  = 1'b1;
                        next_st.nvm_rec = next_st.zero;
                    end
                    if (i_apb.pwdata[ZRJ_CTRL_TGO] && i_apb.pwdata[ZRJ_CTRL_TEACH])
                        next_st.teach_pend = 1'b1;
                end
                ZRJ_OFS_OFFSET:
                    next_st.offset = clamp(i_apb.pwdata, ZRJ_OFFSET_MIN, ZRJ_OFFSET_MAX);
                ZRJ_OFS_THR_HIGH:
                    next_st.thr_high = i_apb.pwdata;
                ZRJ_OFS_THR_LOW:
                    next_st.thr_low = i_apb.pwdata;
                ZRJ_OFS_HYST:
                    next_st.hyst = (i_apb.pwdata[31]) ? 32'sh0 : i_apb.pwdata;
                ZRJ_OFS_LIN_PTS:
                begin
                    next_st.lin_p1 = i_apb.pwdata[15:0];
                    next_st.lin_p2 = i_apb.pwdata[31:16];
                end
                default:
                    next_st.prdata = next_st.prdata;
            endcase
        end
    end

    // The whole state in one register
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            st <= ST_RST;
        else
            st <= next_st;
    end

    // All outputs come straight from state flops
    assign o_pready    = st.pready;
    assign o_prdata    = st.prdata;
    assign o_pslverr   = st.pslverr;
    assign o_nvm_wr    = st.nvm_wr;
    assign o_nvm_rec   = st.nvm_rec;
    assign o_dev_value = st.dev_out;
    assign o_lin_code  = st.lin_out;
    assign o_high      = st.judge[2]; // One-hot bits, no compare after the flop
    assign o_pass      = st.judge[1];
    assign o_low       = st.judge[0];

endmodule : zrj_top

// ==== pkg/zrj_pkg.sv ====
// Purpose: Shared constants and carriers for the zero reset and judgment stage
// Assumes: Values are signed fixed point counts of 0.001 units
// Notes:   Register offsets are byte addresses on a 32-bit APB slave
package zrj_pkg;

    // Clock and long-press timing
    localparam int unsigned ZRJ_CLK_HZ       = 250_000_000;
    localparam int unsigned ZRJ_ESC_HOLD_MS  = 2000;
    localparam int unsigned ZRJ_ESC_HOLD_CYC = (ZRJ_CLK_HZ / 1000) * ZRJ_ESC_HOLD_MS;

    // Register byte offsets
    localparam logic [11:0] ZRJ_OFS_CTRL     = 12'h000;
    localparam logic [11:0] ZRJ_OFS_OFFSET   = 12'h004;
    localparam logic [11:0] ZRJ_OFS_THR_HIGH = 12'h008;
    localparam logic [11:0] ZRJ_OFS_THR_LOW  = 12'h00c;
    localparam logic [11:0] ZRJ_OFS_HYST     = 12'h010;
    localparam logic [11:0] ZRJ_OFS_LIN_PTS  = 12'h014;
    localparam logic [11:0] ZRJ_OFS_STATUS   = 12'h018;
    localparam logic [11:0] ZRJ_OFS_ZERO_LVL = 12'h01c;
    localparam logic [11:0] ZRJ_OFS_DEV      = 12'h020;

    // Control register bit positions
    localparam int unsigned ZRJ_CTRL_TEACH   = 0;
    localparam int unsigned ZRJ_CTRL_HOLDTYP = 1;
    localparam int unsigned ZRJ_CTRL_RETAIN  = 2;
    localparam int unsigned ZRJ_CTRL_SAVE    = 3;
    localparam int unsigned ZRJ_CTRL_TGO     = 4;

    // Status register bit positions
    localparam int unsigned ZRJ_STS_ZEROED   = 0;
    localparam int unsigned ZRJ_STS_HIGH     = 1;
    localparam int unsigned ZRJ_STS_PASS     = 2;
    localparam int unsigned ZRJ_STS_LOW      = 3;
    localparam int unsigned ZRJ_STS_FREEZE   = 4;
    localparam int unsigned ZRJ_STS_TPEND    = 5;

    // Ranges and reset values
    localparam logic signed [31:0] ZRJ_OFFSET_MIN = -32'sd999990;
    localparam logic signed [31:0] ZRJ_OFFSET_MAX = 32'sd999999;
    localparam logic signed [31:0] ZRJ_OFFSET_RST = 32'sh0;
    localparam logic signed [31:0] ZRJ_THR_HI_RST = 32'sh0;
    localparam logic signed [31:0] ZRJ_THR_LO_RST = 32'sh0;
    localparam logic signed [31:0] ZRJ_HYST_RST   = 32'sh0;
    localparam logic [15:0]        ZRJ_LIN_P1_RST = 16'h0000;
    localparam logic [15:0]        ZRJ_LIN_P2_RST = 16'hffff;

    // Judgment states, one-hot
    typedef enum logic [2:0] {
        ZRJ_J_LOW  = 3'b001,
        ZRJ_J_PASS = 3'b010,
        ZRJ_J_HIGH = 3'b100
    } zrj_judge_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } zrj_apb_req_t;

    // Non-volatile store record: zero state and level
    typedef struct packed {
        logic               zeroed;
        logic signed [31:0] level;
    } zrj_nvm_rec_t;

endpackage : zrj_pkg

// ==== tb/tb_zero_reset_and_judgment.sv ====
// Purpose: Self-checking bench for the zero reset and judgment stage
// Assumes: Escape hold shortened to 20 cycles
// Notes:   Random samples use a fixed seed
module tb_zero_reset_and_judgment;
    timeunit 1ns;
    timeprecision 1ns;
    import zrj_pkg::*;

    logic               clk = 0, rstn = 0, ks = 0, ke = 0, ts = 0, fz = 0, val = 0, ha = 0;
    logic signed [31:0] mv = 0, hv = 0, dev;
    zrj_apb_req_t       req = '0;
    zrj_nvm_rec_t       srec, nrec;
    logic               pready, perr, nwr, oh, op, ol, er;
    logic [31:0]        prdata, rd;
    logic [15:0]        lin;
    logic [2:0]         jp;
    int                 errors = 0, compares = 0, cnt = 0, seed = 32'h11f7, hi, lo, hy, v, w, wc;
    int                 cor[6] = '{1001, 901, 900, -1001, -901, -900};

    initial
        forever #2 clk = ~clk;

    zrj_top #(.P_ESC_HOLD_CYC(20)) zrj_top_inst (
        .i_ref_clk(clk), .i_rstn(rstn), .i_apb(req), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(perr), .i_key_set(ks), .i_key_esc(ke), .i_thr_sel_high(ts),
        .i_output_freeze_input(fz), .i_meas_valid(val), .i_meas_value(mv), .i_hold_active(ha),
        .i_hold_value(hv), .i_nvm_rec(srec), .o_nvm_wr(nwr), .o_nvm_rec(nrec),
        .o_dev_value(dev), .o_lin_code(lin), .o_high(oh), .o_pass(op), .o_low(ol));
    zrj_store zrj_store_inst (.i_ref_clk(clk), .i_wr(nwr), .i_rec(nrec), .o_rec(srec), .o_writes(wc));

    task automatic report_and_stop;
        $display("counts errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, s, x);
        end
    endtask : chk

    // Setup, access, then hold until ready is seen high at a rising edge; data taken at that edge
    task automatic apb(input logic wt, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, wt, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            errors++;
        rd = prdata;
        er = perr;
        req <= '0;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask : rdc

    task automatic zst(input logic [31:0] x);
        apb(1'b0, ZRJ_OFS_STATUS, 32'h0);
        chk({31'h0, rd[0]}, x);
    endtask : zst

    // One valid pulse, then wait out the two-edge judgment path
    task automatic smp(input int x);
        @(posedge clk);
        mv <= x;
        val <= 1'b1;
        @(posedge clk);
        val <= 1'b0;
        repeat (2) @(posedge clk);
        @(posedge clk);
    endtask : smp

    task automatic press(input logic esc, input int n);
        @(posedge clk);
        if (esc)
            ke <= 1'b1;
        else
            ks <= 1'b1;
        repeat (n) @(posedge clk);
        ke <= 1'b0;
        ks <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : press

    task automatic rst;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
    endtask : rst

    function automatic logic [2:0] jdg(input logic [2:0] p, input int x);
        if (p == ZRJ_J_HIGH && x > hi - hy)
            return p;
        if (p == ZRJ_J_LOW && x < lo + hy)
            return p;
        return x > hi ? ZRJ_J_HIGH : (x < lo ? ZRJ_J_LOW : ZRJ_J_PASS);
    endfunction : jdg

    task automatic sj(input int x);
        smp(x);
        jp = jdg(jp, x);
        chk({29'h0, oh, op, ol}, {29'h0, jp});
        chk(dev, x);
    endtask : sj

    // A hang counts as a mismatch
    always @(posedge clk)
    begin
        cnt++;
        if (cnt == 40000)
        begin
            errors++;
            report_and_stop;
        end
    end

    initial
    begin
        rst;
        rdc(ZRJ_OFS_LIN_PTS, 32'hffff0000);
        rdc(ZRJ_OFS_STATUS, 32'h4);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, ZRJ_OFS_OFFSET, -2000000);
        rdc(ZRJ_OFS_OFFSET, ZRJ_OFFSET_MIN);
        apb(1'b1, ZRJ_OFS_OFFSET, 2000000);
        rdc(ZRJ_OFS_OFFSET, ZRJ_OFFSET_MAX);
        $display("test registers done");
        apb(1'b1, ZRJ_OFS_OFFSET, 500);
        apb(1'b1, ZRJ_OFS_LIN_PTS, 32'h30001000);
        smp(7000);
        press(1'b0, 6);
        rdc(ZRJ_OFS_ZERO_LVL, 7000);
        smp(7000);
        chk(dev, 500);
        chk(lin, 16'h2000);
        smp(7250);
        chk(dev, 750);
        press(1'b1, 10);
        zst(1);
        press(1'b1, 40);
        zst(0);
        apb(1'b1, ZRJ_OFS_CTRL, 32'h2);
        hv <= 3000;
        press(1'b0, 6);
        zst(0);
        ha <= 1'b1;
        press(1'b0, 6);
        rdc(ZRJ_OFS_ZERO_LVL, 3000);
        press(1'b1, 40);
        ha <= 1'b0;
        $display("test zeroing done");
        // Retention on: every zero and cancel reaches the store
        apb(1'b1, ZRJ_OFS_CTRL, 32'h4);
        press(1'b0, 6);
        chk(srec.level, 7250);
        rst;
        rdc(ZRJ_OFS_ZERO_LVL, 7250);
        apb(1'b1, ZRJ_OFS_CTRL, 32'h4);
        press(1'b1, 40);
        apb(1'b1, ZRJ_OFS_CTRL, 32'h0);
        press(1'b0, 6);
        rst;
        zst(0);
        press(1'b0, 6);
        apb(1'b1, ZRJ_OFS_CTRL, 32'h8);
        repeat (2) @(posedge clk);
        chk(wc, 3);
        rst;
        zst(1);
        press(1'b1, 40);
        $display("test retention done");
        hi = 1000;
        lo = -1000;
        hy = 100;
        jp = ZRJ_J_PASS;
        apb(1'b1, ZRJ_OFS_THR_HIGH, hi);
        apb(1'b1, ZRJ_OFS_THR_LOW, lo);
        apb(1'b1, ZRJ_OFS_HYST, hy);
        foreach (cor[i])
            sj(cor[i]);
        repeat (40)
            sj($random(seed) % 1500);
        $display("test judgment done");
        @(posedge clk);
        fz <= 1'b1;
        repeat (8) @(posedge clk);
        v = dev;
        w = {oh, op, ol};
        smp(1500);
        chk(dev, v);
        chk({29'h0, oh, op, ol}, w);
        jp = jdg(jp, 1500);
        @(posedge clk);
        fz <= 1'b0;
        repeat (8) @(posedge clk);
        sj(1500);
        $display("test freeze done");
        ts <= 1'b1;
        apb(1'b1, ZRJ_OFS_CTRL, 32'h11);
        smp(1200);
        press(1'b0, 6);
        zst(0);
        rdc(ZRJ_OFS_THR_HIGH, 1200);
        ts <= 1'b0;
        ha <= 1'b1;
        hv <= -1300;
        apb(1'b1, ZRJ_OFS_CTRL, 32'h11);
        smp(-50);
        rdc(ZRJ_OFS_THR_LOW, -1300);
        ha <= 1'b0;
        hi = 1200;
        lo = -1300;
        jp = ZRJ_J_PASS;
        sj(-1400);
        $display("test teach done");
        report_and_stop;
    end
endmodule : tb_zero_reset_and_judgment

// ==== tb/zrj_checker.sv ====
// Purpose: Port-level assertions for the zero reset and judgment stage
// Assumes: Freeze pin passes a 3-flop synchroniser plus one agree stage
// Notes:   Bound to zrj_top at the foot of this file
module zrj_checker
    import zrj_pkg::*;
#(
    parameter int unsigned P_ESC_HOLD_CYC = ZRJ_ESC_HOLD_CYC
)
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rstn,
    input  zrj_pkg::zrj_apb_req_t i_apb,
    input  wire logic             o_pready,
    input  wire logic [31:0]      o_prdata,
    input  wire logic             o_pslverr,
    input  wire logic             i_output_freeze_input,
    input  wire logic             o_nvm_wr,
    input  zrj_pkg::zrj_nvm_rec_t o_nvm_rec,
    input  wire logic [31:0]      o_dev_value,
    input  wire logic [15:0]      o_lin_code,
    input  wire logic             o_high,
    input  wire logic             o_pass,
    input  wire logic             o_low
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    // Freeze pin run length; seven leaves slack for the synchroniser
    logic [2:0] fz_cnt;
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            fz_cnt <= 3'h0;
        else if (!i_output_freeze_input)
            fz_cnt <= 3'h0;
        else if (fz_cnt != 3'h7)
            fz_cnt <= fz_cnt + 3'h1;
    end

    a_judge_onehot: assert property ($onehot({o_high, o_pass, o_low}))
        else $error("judgment not one-hot");
    a_reset_values: assert property ($rose(i_rstn) |-> o_pass && !o_high && !o_low && !o_pready
        && o_dev_value == 32'h0 && o_lin_code == 16'h0)
        else $error("outputs not at reset values");
    a_apb_answer: assert property (i_apb.psel && !i_apb.penable |=> o_pready)
        else $error("no ready after setup");
    a_apb_idle: assert property (!i_apb.psel |=> !o_pready)
        else $error("ready without request");
    a_ready_one: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_err_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error without ready or with data");
    a_freeze_hold: assert property (fz_cnt == 3'h7 |-> $stable(o_dev_value) &&
        $stable(o_lin_code) && $stable({o_high, o_pass, o_low}))
        else $error("outputs moved while frozen");
    a_store_pulse: assert property (o_nvm_wr |=> !o_nvm_wr && $stable(o_nvm_rec))
        else $error("store write not a clean pulse");
endmodule : zrj_checker

bind zrj_top zrj_checker #(.P_ESC_HOLD_CYC(P_ESC_HOLD_CYC)) zrj_checker_inst (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_apb(i_apb), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_output_freeze_input(i_output_freeze_input),
    .o_nvm_wr(o_nvm_wr), .o_nvm_rec(o_nvm_rec), .o_dev_value(o_dev_value),
    .o_lin_code(o_lin_code), .o_high(o_high), .o_pass(o_pass), .o_low(o_low));

// ==== tb/zrj_store.sv ====
// Purpose: Behavioural non-volatile store beside the zero reset stage
// Assumes: Contents outlive the design's reset, as across a power cycle
// Notes:   Counts writes so wear from repeated zeroing is visible
module zrj_store
    import zrj_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_wr,
    input  zrj_pkg::zrj_nvm_rec_t i_rec,
    output zrj_pkg::zrj_nvm_rec_t o_rec,
    output int                    o_writes
);
    timeunit 1ns;
    timeprecision 1ns;

    // Blank at first power-up, so the stage starts unzeroed
    initial
    begin
        o_rec = '0;
        o_writes = 0;
    end

    // No reset on purpose: a power cycle must not lose the record
    always @(posedge i_ref_clk)
    begin
        if (i_wr)
        begin
            o_rec <= i_rec;
            o_writes <= o_writes + 1;
        end
    end
endmodule : zrj_store
